// ### design/safe_torque_off_supervisor.sv
// safe torque off supervisor: channel filtering, safe state, brake, counter clear, mismatch alarm
// Behaviour
// [R1] safe-ready stays low while torque is removed
// [R2] both channels on and servo off gives safe-ready and servo-ready state
// [R3] entering safe state drives brake output off at once
// [R4] servo-off delay is bypassed when safe state is entered
// [R5] safe state lets the motor coast, no braking torque
// [R6] mode 0 clears deviation counter entering servo-off or safe state; mode sampled at restart
// [R7] mode 2 also clears it on entering overtravel
// [R8] channels off with jumper removed gives safe state, no current, display flag
// [R9] either channel off gives safe state; other on for 10 s raises mismatch alarm
// [R10] present level of each channel is readable as a monitor value
// [R11] external device switches both channels together
// [R12] operable state returns only after both channels are on again
// [R13] stop monitor output on only when both channels off, within 5 ms
// [R14] both channels off removes motor power within 5 ms
// [R15] low test pulses up to 1 ms are tolerated; longer reads as off
// [R16] leaving safe state is refused unless both channels read on
// [R17] channels are synchronised and short low pulses filtered before use
// [R18] mismatch alarm latches until both channels on and alarm reset
`timescale 1ns/1ps
`include "sto_supervisor_regs.svh"

module safe_torque_off_supervisor (
  input  wire logic                              clock,                // 25 MHz clock
  input  wire logic                              nrst,                 // sync reset, active low
  input  wire logic                              safety_input_a,       // channel a, high is on
  input  wire logic                              safety_input_b,       // channel b, high is on
  input  wire logic                              servo_on_cmd,         // request to energise
  input  wire logic                              overtravel,           // overtravel active
  input  wire logic                              alarm_reset,          // alarm reset pulse
  input  wire sto_supervisor_pkg::clear_mode_t   counter_clear_mode,   // sampled after reset
  input  wire logic                              servo_off_delay_done, // servo-off wait elapsed
  output sto_supervisor_pkg::sto_status_s        status,               // registered status
  output logic [1:0]                             safety_input_monitor, // {b,a} filtered levels
  output logic                                   deviation_clear       // one-cycle clear pulse
);
  import sto_supervisor_pkg::*;

  // ==========================================================
  // input synchronisers and low-pulse filters
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] chan_on;
  logic [15:0] low_cnt [2];

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
    end else begin
      sync1 <= {safety_input_b, safety_input_a}; // R17
      sync2 <= sync1;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_filt
    always_ff @(posedge clock) begin
      if (!nrst) begin
        low_cnt[i] <= 16'h0;
        chan_on[i] <= 1'b0;
      end else if (sync2[i]) begin
        low_cnt[i] <= 16'h0;
        chan_on[i] <= 1'b1;
      end else if (low_cnt[i] >= 16'(`STO_PULSE_CYC)) begin
        chan_on[i] <= 1'b0; // R15 R17
      end else begin
        low_cnt[i] <= low_cnt[i] + 16'h1; // R15
      end
    end
  end

  logic both_on;
  logic both_off;
  logic any_off;
  assign both_on  = chan_on[0] & chan_on[1];
  assign both_off = ~chan_on[0] & ~chan_on[1];
  assign any_off  = ~both_on;

  always_ff @(posedge clock) begin
    if (!nrst) safety_input_monitor <= 2'h0;
    else safety_input_monitor <= chan_on; // R10
  end

  // ==========================================================
  // restart-latched clear mode
  clear_mode_t mode;
  logic        mode_taken;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      mode       <= `STO_CLR_MODE_SERVO_OFF_STATE;
      mode_taken <= 1'b0;
    end else if (!mode_taken) begin
      mode       <= counter_clear_mode; // R6
      mode_taken <= 1'b1;
    end
  end

  // ==========================================================
  // servo state machine
  servo_state_e state;
  servo_state_e next_state;

  always_comb begin
    next_state = state;
    case (state)
      st_safe:  if (both_on) next_state = st_servo_off_state; // R12 R16
      st_servo_off_state:  if (any_off) next_state = st_safe;
                else if (servo_on_cmd) next_state = st_ready;
      st_ready: if (any_off) next_state = st_safe; // R8 R9 R14
                else if (!servo_on_cmd) next_state = st_servo_off_state;
      default:  next_state = st_safe;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) state <= st_safe;
    else state <= next_state;
  end

  // ==========================================================
  // deviation counter clear
  logic ot_q;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ot_q            <= 1'b0;
      deviation_clear <= 1'b0;
    end else begin
      ot_q            <= overtravel;
      deviation_clear <= (mode == `STO_CLR_MODE_SERVO_OFF_STATE || mode == `STO_CLR_MODE_OT)
                         && next_state != state && next_state != st_ready // R6
                         || (mode == `STO_CLR_MODE_OT && overtravel && !ot_q); // R7
    end
  end

  // ==========================================================
  // mismatch timer and alarm
  logic [27:0] mis_cnt;
  logic        mismatch;
  assign mismatch = chan_on[0] ^ chan_on[1];

  always_ff @(posedge clock) begin
    if (!nrst) mis_cnt <= 28'h0;
    else if (!mismatch) mis_cnt <= 28'h0;
    else if (mis_cnt < 28'(`STO_MISMATCH_CYC)) mis_cnt <= mis_cnt + 28'h1;
  end

  logic alarm;
  always_ff @(posedge clock) begin
    if (!nrst) alarm <= 1'b0;
    else if (mismatch && mis_cnt >= 28'(`STO_MISMATCH_CYC) - 28'h1) alarm <= 1'b1; // R9
    else if (both_on && alarm_reset) alarm <= 1'b0; // R18
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge clock) begin
    if (!nrst) begin
      status <= '0;
    end else begin
      status.torque_removed_state <= (next_state == st_safe); // R8
      status.safe_ready           <= (next_state == st_servo_off_state) & both_on; // R1 R2
      status.stop_monitor_output  <= both_off; // R13
      status.torque_enable        <= (next_state == st_ready); // R14
      status.coast                <= (next_state == st_safe); // R5
      status.mismatch_alarm       <= alarm | (mismatch && mis_cnt >= 28'(`STO_MISMATCH_CYC) - 28'h1);
      if (next_state == st_safe) status.brake_control_output <= 1'b0; // R3 R4
      else if (next_state == st_ready) status.brake_control_output <= 1'b1;
      else if (servo_off_delay_done) status.brake_control_output <= 1'b0;
    end
  end
endmodule : safe_torque_off_supervisor

// ### design/sto_supervisor_regs.svh
// timing counts and field values for the safe torque off supervisor
`ifndef STO_SUPERVISOR_REGS_SVH
`define STO_SUPERVISOR_REGS_SVH
`define STO_CLK_HZ           25000000
`define STO_PULSE_MAX_US     1000
`define STO_PULSE_CYC        ((`STO_PULSE_MAX_US * (`STO_CLK_HZ / 1000000)))
`define STO_MISMATCH_S       10
`define STO_MISMATCH_CYC     (`STO_MISMATCH_S * `STO_CLK_HZ)
`define STO_CLR_MODE_SERVO_OFF_STATE    2'h0
`define STO_CLR_MODE_OT      2'h2
`endif

// ### design/sto_supervisor_pkg.sv
// types for the safe torque off supervisor
package sto_supervisor_pkg;
  typedef enum logic [1:0] {
    st_ready = 2'b00,
    st_servo_off_state  = 2'b01,
    st_safe  = 2'b10
  } servo_state_e;

  typedef struct packed {
    logic safe_ready;
    logic stop_monitor_output;
    logic brake_control_output;
    logic torque_enable;
    logic coast;
    logic torque_removed_state;
    logic mismatch_alarm;
  } sto_status_s;

  typedef logic [1:0] clear_mode_t;
endpackage : sto_supervisor_pkg

// ### verification/sto_chk_sva.sv
// assertions for the safe torque off supervisor
`timescale 1ns/1ps
module sto_chk (
  input wire logic                            clock,                // clock
  input wire logic                            nrst,                 // reset
  input wire logic                            alarm_reset,          // alarm reset
  input wire sto_supervisor_pkg::clear_mode_t counter_clear_mode,   // clear mode
  input wire sto_supervisor_pkg::sto_status_s status,               // status
  input wire logic [1:0]                      safety_input_monitor, // levels
  input wire logic                            deviation_clear       // clear pulse
);
  import sto_supervisor_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // ==========
  // checks
  a_ready_off_safe: assert property (status.torque_removed_state |-> !status.safe_ready)
    else $error("safe ready high in safe state");
  a_ready_needs_on: assert property (status.safe_ready |-> safety_input_monitor == 2'h3)
    else $error("safe ready without both channels");
  a_brake_safe: assert property (status.torque_removed_state |-> !status.brake_control_output)
    else $error("brake released in safe state");
  a_coast_safe: assert property (status.torque_removed_state |-> status.coast && !status.torque_enable)
    else $error("torque in safe state");
  a_monitor_both_off: assert property (status.stop_monitor_output |-> safety_input_monitor == 2'h0)
    else $error("stop monitor with a channel on");
  a_exit_both_on: assert property ($fell(status.torque_removed_state) |-> safety_input_monitor == 2'h3)
    else $error("safe state left early");
  a_clear_on_entry: assert property ($rose(status.torque_removed_state)
    && ($past(status.safe_ready) || $past(status.torque_enable))
    && counter_clear_mode == 2'h0 |-> deviation_clear)
    else $error("no clear on safe entry");
  a_clear_one_cycle: assert property (deviation_clear |=> !deviation_clear)
    else $error("clear pulse too long");
  a_alarm_latched: assert property (status.mismatch_alarm && !alarm_reset |=> status.mismatch_alarm)
    else $error("alarm dropped");
  c_safe: cover property ($rose(status.torque_removed_state));
  c_ready: cover property ($rose(status.safe_ready));
  c_clear: cover property (deviation_clear);
endmodule : sto_chk
bind safe_torque_off_supervisor sto_chk sto_chk_inst (.clock(clock), .nrst(nrst), .alarm_reset(alarm_reset),
  .counter_clear_mode(counter_clear_mode), .status(status), .safety_input_monitor(safety_input_monitor),
  .deviation_clear(deviation_clear));

// ### verification/sto_safety_device.sv
// model of the external safety device driving both channels
`timescale 1ns/1ps
module sto_safety_device (
  input  wire logic field_clear,    // protective field clear
  input  wire logic drop_one,       // commanded channel fault
  output logic      safety_input_a, // channel a
  output logic      safety_input_b  // channel b
);
  // ==========
  // both channels switch together unless a fault is commanded
  assign safety_input_a = field_clear && !drop_one;
  assign safety_input_b = field_clear;
endmodule : sto_safety_device

// ### verification/tb_top.sv
// testbench for the safe torque off supervisor
`timescale 1ns/1ps
module tb_top;
  import sto_supervisor_pkg::*;
  logic clock, nrst, field_clear, drop_one, servo_on_cmd, a, b, ot, dly;
  logic [1:0]  mode;
  logic [1:0]  safety_input_monitor;
  logic        deviation_clear;
  sto_status_s status;
  int          error_cnt, checks_done, cyc;
  sto_safety_device sto_safety_device_inst (.field_clear(field_clear), .drop_one(drop_one),
    .safety_input_a(a), .safety_input_b(b));
  safe_torque_off_supervisor safe_torque_off_supervisor_inst (.clock(clock), .nrst(nrst), .safety_input_a(a),
    .safety_input_b(b), .servo_on_cmd(servo_on_cmd), .overtravel(ot), .alarm_reset(1'b0),
    .counter_clear_mode(mode), .servo_off_delay_done(dly), .status(status),
    .safety_input_monitor(safety_input_monitor), .deviation_clear(deviation_clear));
  // ==========
  // tasks
  task automatic check(string name, logic [1:0] seen, logic [1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic cycles(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cycles
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  initial begin
    clock = 0;
    forever #20 clock = !clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      test_done();
    end
  end
  // ==========
  // sequence
  initial begin
    {nrst, field_clear, drop_one, servo_on_cmd, ot, dly, mode} = 8'h00;
    cycles(4);
    nrst = 1;
    cycles(5);
    check("safe", status.torque_removed_state, 2'h1);
    field_clear = 1;
    cycles(10);
    check("monitor", safety_input_monitor, 2'h3);
    check("ready", status.safe_ready, 2'h1);
    servo_on_cmd = 1;
    cycles(5);
    check("torque", status.torque_enable, 1);
    field_clear = 0;
    cycles(20000);
    field_clear = 1;
    cycles(10);
    check("pulse", status.torque_enable, 1);
    field_clear = 0;
    cycles(25010);
    check("safe", status.torque_removed_state, 1);
    check("brake", status.brake_control_output, 0);
    check("coast", status.coast, 1);
    check("edm", status.stop_monitor_output, 1);
    check("ready", status.safe_ready, 0);
    field_clear = 1;
    cycles(10);
    check("torque", status.torque_enable, 1);
    drop_one = 1;
    cycles(25010);
    check("safe", status.torque_removed_state, 1);
    check("edm", status.stop_monitor_output, 0);
    check("monitor", safety_input_monitor, 2'h2);
    drop_one = 0;
    cycles(10);
    check("exit", status.torque_removed_state, 2'h0);
    check("brake", status.brake_control_output, 2'h1);
    servo_on_cmd = 0;
    dly = 1;
    cycles(3);
    check("brake", status.brake_control_output, 2'h0);
    nrst = 0;
    mode = 2'h2;
    cycles(4);
    nrst = 1;
    cycles(12);
    check("servo_off_state", status.safe_ready, 2'h1);
    ot = 1;
    cycles(1);
    check("clear", deviation_clear, 2'h1);
    cycles(1);
    check("clear", deviation_clear, 2'h0);
    test_done();
  end
endmodule : tb_top
